// *** shared/msp_pkg.sv ***
// Purpose: constants and types shared by the multi-speed interrupt positioner
// Assumes: one 20 MHz clock, synchronous active-low reset
// Notes: speeds are phase increments of a 24-bit accumulator; distances are step counts
// Function
// - in two-speed mode a start runs amount one at speed one, then amount two at speed two.
// - multi-speed motion chains table entries back to back without stopping between them.
// - in interrupt stop mode an edge on interrupt one during travel starts a deceleration to standstill; interrupt two is ignored.
// - in interrupt feed mode the axis runs until the interrupt, then feeds the set distance.
// - in interrupt two-speed feed the first interrupt switches from stage one to stage two speed.
// - after that switch the second interrupt feeds the set distance and then stops.
// - single-speed positioning runs at speed and decelerates to halt on the target.
package msp_pkg;

	localparam int CLK_MHZ      = 20;
	localparam int RAMP_TICK_US = 1000;
	localparam int RAMP_CYC     = RAMP_TICK_US * CLK_MHZ;

	localparam int SPEED_W = 16;
	localparam int DIST_W  = 32;
	localparam int PHASE_W = 24;
	localparam int TBL_AW  = 3;
	localparam int TBL_N   = 8;

	localparam logic [SPEED_W-1:0] CRAWL_SPEED = 16'h0010;
	localparam logic [SPEED_W-1:0] SPEED_RST   = 16'h0000;
	localparam logic [DIST_W-1:0]  DIST_RST    = 32'h0000_0000;
	localparam logic [PHASE_W-1:0] PHASE_RST   = 24'h00_0000;

	localparam logic [2:0] MODE_ONE_SPEED  = 3'h0;
	localparam logic [2:0] MODE_TWO_SPEED  = 3'h1;
	localparam logic [2:0] MODE_MULTI      = 3'h2;
	localparam logic [2:0] MODE_INT_STOP   = 3'h3;
	localparam logic [2:0] MODE_INT_FEED1  = 3'h4;
	localparam logic [2:0] MODE_INT_FEED2  = 3'h5;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b0_0001,
		ST_FETCH = 5'b0_0010,
		ST_RUN   = 5'b0_0100,
		ST_FREE  = 5'b0_1000,
		ST_DECEL = 5'b1_0000
	} msp_state_t;

endpackage

// *** rtl/msp_tbl_mem.sv ***
// Purpose: positioning table holding one speed and one movement amount per entry
// Assumes: single clock, write and read ports independent
// Notes: read data are registered, so an address shows its entry one cycle later
`timescale 1ns/1ps
module msp_tbl_mem
	import msp_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                we,
	input  wire logic [TBL_AW-1:0]   waddr,
	input  wire logic [SPEED_W-1:0]  wspeed,
	input  wire logic [DIST_W-1:0]   wamount,
	input  wire logic [TBL_AW-1:0]   raddr,
	output logic      [SPEED_W-1:0]  rspeed,
	output logic      [DIST_W-1:0]   ramount
);
	logic [SPEED_W-1:0] mem_speed  [TBL_N];
	logic [DIST_W-1:0]  mem_amount [TBL_N];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem_speed[waddr]  <= wspeed;
			mem_amount[waddr] <= wamount;
		end
		rspeed  <= mem_speed[raddr];
		ramount <= mem_amount[raddr];
	end
endmodule // msp_tbl_mem

// *** rtl/msp_positioner.sv ***
// Purpose: one-axis positioning sequencer producing a step pulse train for a drive amplifier
// Assumes: start and configuration come from same-clock logic; interrupt pins are asynchronous
// Notes: configuration is latched at start; amount_one is also the feed distance after interrupts
`timescale 1ns/1ps
module msp_positioner
	import msp_pkg::*;
#(
	parameter int RAMP_TICK_CYC = RAMP_CYC
)
(
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                start,
	input  wire logic [2:0]          mode,
	input  wire logic [SPEED_W-1:0]  speed_one,
	input  wire logic [SPEED_W-1:0]  speed_two,
	input  wire logic [DIST_W-1:0]   amount_one,
	input  wire logic [DIST_W-1:0]   amount_two,
	input  wire logic [SPEED_W-1:0]  decel_step,
	input  wire logic [TBL_AW:0]     table_count,
	input  wire logic                tbl_we,
	input  wire logic [TBL_AW-1:0]   tbl_waddr,
	input  wire logic [SPEED_W-1:0]  tbl_wspeed,
	input  wire logic [DIST_W-1:0]   tbl_wamount,
	input  wire logic                intr_one_pin,
	input  wire logic                intr_two_pin,
	output logic                     step_out,
	output logic                     busy,
	output logic                     done,
	output logic      [SPEED_W-1:0]  speed
);
	msp_state_t          state,  next_state;
	logic [2:0]          mode_r, next_mode_r;
	logic [DIST_W-1:0]   remaining, next_remaining;
	logic [PHASE_W-1:0]  phase,  next_phase;
	logic [SPEED_W-1:0]  next_speed, cfg_speed2, next_cfg_speed2, cfg_decel, next_cfg_decel;
	logic [DIST_W-1:0]   cfg_amt1, next_cfg_amt1, cfg_amt2, next_cfg_amt2;
	logic [TBL_AW:0]     cfg_count, next_cfg_count;
	logic [TBL_AW-1:0]   idx, next_idx;
	logic                seg_last, next_seg_last, target, next_target, stage, next_stage;
	logic                next_step_out, next_busy, next_done;
	logic [15:0]         tick_cnt, next_tick_cnt;
	logic                tick;
	logic [SPEED_W-1:0]  rd_speed;
	logic [DIST_W-1:0]   rd_amount;
	logic [1:0]          i1_sync, i2_sync;
	logic                i1_q, i2_q;
	logic                rise_one, rise_two;

	msp_tbl_mem u_tbl (
		.mclk    (mclk),
		.we      (tbl_we),
		.waddr   (tbl_waddr),
		.wspeed  (tbl_wspeed),
		.wamount (tbl_wamount),
		.raddr   (idx),
		.rspeed  (rd_speed),
		.ramount (rd_amount)
	);

	// interrupt pins: two flops, then a third for the edge; the edge compares stage two with the third flop
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			i1_sync <= 2'h0;
			i2_sync <= 2'h0;
			i1_q    <= 1'b0;
			i2_q    <= 1'b0;
		end else begin
			i1_sync <= {i1_sync[0], intr_one_pin};
			i2_sync <= {i2_sync[0], intr_two_pin};
			i1_q    <= i1_sync[1];
			i2_q    <= i2_sync[1];
		end
	end
	assign rise_one = i1_sync[1] & ~i1_q;
	assign rise_two = i2_sync[1] & ~i2_q;

	// ramp tick divider; runs free so deceleration steps stay evenly spaced
	always_comb begin
		tick          = (tick_cnt == 16'(RAMP_TICK_CYC - 1));
		next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
	end

	logic [PHASE_W:0]  sum;
	logic              moving, stepping, counting, brake;
	logic [DIST_W-1:0] rem_dec;
	logic [79:0]       brake_lhs, brake_rhs;
	logic [SPEED_W:0]  floor_v, decel_lim;

	always_comb begin
		next_state      = state;
		next_mode_r     = mode_r;
		next_remaining  = remaining;
		next_phase      = phase;
		next_speed      = speed;
		next_cfg_speed2 = cfg_speed2;
		next_cfg_amt1   = cfg_amt1;
		next_cfg_amt2   = cfg_amt2;
		next_cfg_decel  = cfg_decel;
		next_cfg_count  = cfg_count;
		next_idx        = idx;
		next_seg_last   = seg_last;
		next_target     = target;
		next_stage      = stage;
		next_busy       = busy;
		next_done       = 1'b0;
		moving    = (state == ST_RUN) || (state == ST_FREE) || (state == ST_DECEL);
		sum       = {1'b0, phase} + (PHASE_W+1)'(speed);
		stepping  = moving && sum[PHASE_W];
		counting  = (state == ST_RUN) || ((state == ST_DECEL) && target);
		rem_dec   = (counting && stepping && remaining != DIST_RST) ? remaining - 32'h0000_0001
			: remaining;
		// brake when the steps left no longer cover the ramp from the present speed
		brake_lhs = (80'(rem_dec) * 80'(cfg_decel)) << (PHASE_W + 1);
		brake_rhs = 80'(RAMP_TICK_CYC) * 80'(speed) * 80'(speed);
		brake     = (brake_lhs <= brake_rhs);
		floor_v   = target ? {1'b0, CRAWL_SPEED} : 17'h0_0000;
		decel_lim = {1'b0, cfg_decel} + floor_v;
		next_step_out  = stepping;
		if (moving) begin
			next_phase = sum[PHASE_W-1:0];
		end
		next_remaining = rem_dec;
		case (state)
			ST_IDLE: begin
				// interrupt edges have no effect here
				if (start) begin
					next_mode_r     = mode;
					next_cfg_speed2 = speed_two;
					next_cfg_amt1   = amount_one;
					next_cfg_amt2   = amount_two;
					next_cfg_decel  = decel_step;
					next_cfg_count  = table_count;
					next_busy       = 1'b1;
					next_phase      = PHASE_RST;
					next_stage      = 1'b0;
					next_speed      = speed_one;
					next_remaining  = amount_one;
					next_target     = 1'b1;
					next_seg_last   = (mode != MODE_TWO_SPEED);
					if (mode == MODE_MULTI) begin
						next_state = ST_FETCH;
					end else if (mode == MODE_ONE_SPEED || mode == MODE_TWO_SPEED) begin
						next_state = ST_RUN;
					end else begin
						next_state  = ST_FREE;
						next_target = 1'b0;
					end
				end
			end
			ST_FETCH: begin
				next_speed     = rd_speed;
				next_remaining = rd_amount;
				next_idx       = idx + 3'h1;
				next_seg_last  = (cfg_count <= 4'h1);
				next_state     = ST_RUN;
			end
			ST_RUN: begin
				if (rem_dec == DIST_RST) begin
					if (seg_last) begin
						next_state = ST_IDLE;
						next_speed = SPEED_RST;
						next_busy  = 1'b0;
						next_done  = 1'b1;
						next_idx   = 3'h0;
					end else if (mode_r == MODE_TWO_SPEED) begin
						next_speed     = cfg_speed2;
						next_remaining = cfg_amt2;
						next_seg_last  = 1'b1;
					end else begin
						// next entry was prefetched, so the hand-over costs no idle cycle
						next_speed     = rd_speed;
						next_remaining = rd_amount;
						next_idx       = idx + 3'h1;
						next_seg_last  = ({1'b0, idx} + 4'h1 >= cfg_count);
					end
				end else if (seg_last && brake) begin
					next_state = ST_DECEL;
				end
			end
			ST_FREE: begin
				if (mode_r == MODE_INT_STOP && rise_one) begin
					next_state = ST_DECEL;
				end else if (mode_r == MODE_INT_FEED1 && rise_one) begin
					next_state     = ST_RUN;
					next_remaining = cfg_amt1;
					next_seg_last  = 1'b1;
					next_target    = 1'b1;
				end else if (mode_r == MODE_INT_FEED2 && !stage && rise_one) begin
					next_speed = cfg_speed2;
					next_stage = 1'b1;
				end else if (mode_r == MODE_INT_FEED2 && stage && rise_two) begin
					next_state     = ST_RUN;
					next_remaining = cfg_amt1;
					next_seg_last  = 1'b1;
					next_target    = 1'b1;
				end
			end
			ST_DECEL: begin
				if ((target && rem_dec == DIST_RST) || (!target && speed == SPEED_RST)) begin
					next_state = ST_IDLE;
					next_speed = SPEED_RST;
					next_busy  = 1'b0;
					next_done  = 1'b1;
					next_idx   = 3'h0;
				end else if (tick) begin
					// ramp down by the configured step; a targeted stop creeps in at crawl speed
					next_speed = ({1'b0, speed} > decel_lim) ? speed - cfg_decel
						: floor_v[SPEED_W-1:0];
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state      <= ST_IDLE;
			mode_r     <= MODE_ONE_SPEED;
			remaining  <= DIST_RST;
			phase      <= PHASE_RST;
			speed      <= SPEED_RST;
			cfg_speed2 <= SPEED_RST;
			cfg_amt1   <= DIST_RST;
			cfg_amt2   <= DIST_RST;
			cfg_decel  <= SPEED_RST;
			cfg_count  <= 4'h0;
			idx        <= 3'h0;
			seg_last   <= 1'b0;
			target     <= 1'b0;
			stage      <= 1'b0;
			step_out   <= 1'b0;
			busy       <= 1'b0;
			done       <= 1'b0;
			tick_cnt   <= 16'h0000;
		end else begin
			state      <= next_state;
			mode_r     <= next_mode_r;
			remaining  <= next_remaining;
			phase      <= next_phase;
			speed      <= next_speed;
			cfg_speed2 <= next_cfg_speed2;
			cfg_amt1   <= next_cfg_amt1;
			cfg_amt2   <= next_cfg_amt2;
			cfg_decel  <= next_cfg_decel;
			cfg_count  <= next_cfg_count;
			idx        <= next_idx;
			seg_last   <= next_seg_last;
			target     <= next_target;
			stage      <= next_stage;
			step_out   <= next_step_out;
			busy       <= next_busy;
			done       <= next_done;
			tick_cnt   <= next_tick_cnt;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_free_in(logic [2:0] m);
		state == ST_FREE && mode_r == m;
	endsequence

	property p_idle_ignores_intr;
		(state == ST_IDLE && !start && (rise_one || rise_two)) |=> state == ST_IDLE;
	endproperty
	a_idle_ignores_intr: assert property (p_idle_ignores_intr)
		else $error("interrupt acted while idle");

	property p_int_stop;
		(s_free_in(MODE_INT_STOP) ##0 rise_one) |=> state == ST_DECEL && !target;
	endproperty
	a_int_stop: assert property (p_int_stop)
		else $error("interrupt stop did not start deceleration");

	property p_feed_one;
		(s_free_in(MODE_INT_FEED1) ##0 rise_one) |=> state == ST_RUN && remaining == cfg_amt1;
	endproperty
	a_feed_one: assert property (p_feed_one)
		else $error("feed after interrupt not loaded with distance");

	property p_stage_change;
		(s_free_in(MODE_INT_FEED2) ##0 (!stage && rise_one)) |=> state == ST_FREE
			&& speed == cfg_speed2 && stage;
	endproperty
	a_stage_change: assert property (p_stage_change)
		else $error("first interrupt did not switch to second speed");

	property p_second_feed;
		(s_free_in(MODE_INT_FEED2) ##0 (stage && rise_two)) |=> state == ST_RUN
			&& remaining == cfg_amt1 && target;
	endproperty
	a_second_feed: assert property (p_second_feed)
		else $error("second interrupt did not start the feed");

	property p_two_speed;
		(state == ST_RUN && mode_r == MODE_TWO_SPEED && !seg_last && rem_dec == DIST_RST)
			|=> state == ST_RUN && speed == cfg_speed2 && remaining == cfg_amt2;
	endproperty
	a_two_speed: assert property (p_two_speed)
		else $error("second speed segment not entered");

	property p_multi_chain;
		(state == ST_RUN && mode_r == MODE_MULTI && !seg_last && rem_dec == DIST_RST)
			|=> state == ST_RUN && busy ##1 busy;
	endproperty
	a_multi_chain: assert property (p_multi_chain)
		else $error("table chain stopped between entries");

	property p_one_speed;
		(state == ST_IDLE && start && mode == MODE_ONE_SPEED)
			|=> state == ST_RUN && speed == $past(speed_one) && remaining == $past(amount_one);
	endproperty
	a_one_speed: assert property (p_one_speed)
		else $error("single-speed start not loaded");

	property p_decel_monotone;
		(state == ST_DECEL) |=> speed <= $past(speed);
	endproperty
	a_decel_monotone: assert property (p_decel_monotone)
		else $error("speed rose during deceleration");

	property p_target_done;
		(done && mode_r != MODE_INT_STOP) |-> remaining == DIST_RST && !busy;
	endproperty
	a_target_done: assert property (p_target_done)
		else $error("positioning finished off target");

endmodule // msp_positioner

// *** verification/msp_drive_model.sv ***
// Purpose: drive amplifier stand-in that counts the step pulses it receives
// Assumes: one motor step per step_out pulse, same clock as the positioner
// Notes: no direction input exists, so only the distance travelled is kept
`timescale 1ns/1ps
module msp_drive_model (
	input  wire logic        mclk,
	input  wire logic        clr,
	input  wire logic        step_out,
	output logic      [31:0] count
);
	always_ff @(posedge mclk) begin
		if (clr) begin
			count <= 32'h0000_0000;
		end else if (step_out) begin
			count <= count + 32'h0000_0001;
		end
	end
endmodule // msp_drive_model

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the positioner, one task per operation pattern
// Assumes: short ramp tick so deceleration ramps finish in a few hundred cycles
// Notes: target modes use decel_step 0, since a crawl-speed tail would last a million cycles
`timescale 1ns/1ps
module testbench;
	import msp_pkg::*;
	logic                mclk;
	logic                rst_b;
	logic                start;
	logic                clr;
	logic                tbl_we;
	logic                intr_one_pin;
	logic                intr_two_pin;
	logic [2:0]          mode;
	logic [SPEED_W-1:0]  speed_one;
	logic [SPEED_W-1:0]  speed_two;
	logic [SPEED_W-1:0]  decel_step;
	logic [SPEED_W-1:0]  tbl_wspeed;
	logic [SPEED_W-1:0]  speed;
	logic [DIST_W-1:0]   amount_one;
	logic [DIST_W-1:0]   amount_two;
	logic [DIST_W-1:0]   tbl_wamount;
	logic [TBL_AW:0]     table_count;
	logic [TBL_AW-1:0]   tbl_waddr;
	logic                step_out;
	logic                busy;
	logic                done;
	logic [31:0]         count;
	logic [31:0]         c0;
	logic [SPEED_W-1:0]  sq[$];
	int                  mismatches;
	int                  checked;

	msp_positioner #(.RAMP_TICK_CYC(8)) u_dut (.mclk, .rst_b, .start, .mode, .speed_one,
		.speed_two, .amount_one, .amount_two, .decel_step, .table_count, .tbl_we,
		.tbl_waddr, .tbl_wspeed, .tbl_wamount, .intr_one_pin, .intr_two_pin, .step_out,
		.busy, .done, .speed);
	msp_drive_model u_drive (.mclk, .clr, .step_out, .count);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic go(input logic [2:0] m, input logic [15:0] s1, input logic [15:0] s2,
			input logic [31:0] a1, input logic [31:0] a2, input logic [15:0] dec);
		mode = m;
		speed_one = s1;
		speed_two = s2;
		amount_one = a1;
		amount_two = a2;
		decel_step = dec;
		start = 1'b1;
		clr = 1'b1;
		tick(1);
		start = 1'b0;
		clr = 1'b0;
		sq = {};
	endtask

	// bounded wait for the drive to have received n steps
	task automatic wait_steps(input logic [31:0] n);
		for (int i = 0; i < 20000 && count < n; i++) tick(1);
		if (count < n) begin
			mismatches++;
			stop_test();
		end
	endtask

	// n cycles of waiting while nonzero speeds are logged in order
	task automatic watch(input int n);
		for (int i = 0; i < n; i++) begin
			if (speed !== 16'h0000 && (sq.size() == 0 || speed !== sq[$])) sq.push_back(speed);
			tick(1);
		end
	endtask

	// busy must hold through the whole pattern
	task automatic wait_done();
		for (int i = 0; i < 20000 && done !== 1'b1; i++) begin
			check(busy, 1'b1);
			watch(1);
		end
		if (done !== 1'b1) begin
			mismatches++;
			stop_test();
		end
		check(busy, 1'b0);
		tick(1);
		check(done, 1'b0);
	endtask

	task automatic pulse(input int which);
		if (which == 1) intr_one_pin = 1'b1;
		else intr_two_pin = 1'b1;
		tick(2);
		// only the pin raised here is lowered, so back-to-back pulses never glitch the other pin
		if (which == 1) intr_one_pin = 1'b0;
		else intr_two_pin = 1'b0;
	endtask

	task automatic idle_intr();
		pulse(1);
		pulse(2);
		tick(10);
		check(busy, 1'b0);
		check(count, 32'h0000_0000);
	endtask

	task automatic one_speed();
		go(MODE_ONE_SPEED, 16'hF000, 16'h0000, 32'h0000_0005, 32'h0000_0000, 16'h0000);
		wait_done();
		check(count, 32'h0000_0005);
		check(sq[0], 16'hF000);
	endtask

	task automatic two_speed();
		go(MODE_TWO_SPEED, 16'hF000, 16'hE000, 32'h0000_0003, 32'h0000_0004, 16'h0000);
		wait_steps(2);
		check(speed, 16'hF000);
		wait_steps(4);
		check(speed, 16'hE000);
		wait_done();
		check(count, 32'h0000_0007);
	endtask

	task automatic multi();
		for (int i = 0; i < 3; i++) begin
			tbl_we = 1'b1;
			tbl_waddr = i[TBL_AW-1:0];
			tbl_wspeed = 16'hF000 - 16'h1000 * i[15:0];
			tbl_wamount = 32'h0000_0002;
			tick(1);
		end
		tbl_we = 1'b0;
		table_count = 4'h3;
		go(MODE_MULTI, 16'h0000, 16'h0000, 32'h0000_0000, 32'h0000_0000, 16'h0000);
		wait_done();
		check(count, 32'h0000_0006);
		check(sq.size(), 32'h0000_0003);
		for (int i = 0; i < 3 && i < sq.size(); i++) check(sq[i], 16'hF000 - 16'h1000 * i);
	endtask

	task automatic int_stop();
		go(MODE_INT_STOP, 16'hF000, 16'h0000, 32'h0000_0000, 32'h0000_0000, 16'h1000);
		tick(40);
		pulse(1);
		// log from here on: the ramp starts inside this wait, so the first levels are kept too
		watch(14);
		check(speed < 16'hF000, 1'b1);
		wait_done();
		check(sq.size(), 32'h0000_000F);
		for (int i = 1; i < sq.size(); i++) check(sq[i-1] - sq[i], 16'h1000);
	endtask

	task automatic int_feed_one();
		go(MODE_INT_FEED1, 16'hF000, 16'h0000, 32'h0000_0003, 32'h0000_0000, 16'h0000);
		wait_steps(4);
		check(busy, 1'b1);
		c0 = count;
		pulse(1);
		wait_done();
		check(count - c0, 32'h0000_0003);
	endtask

	task automatic int_feed_two();
		go(MODE_INT_FEED2, 16'hF000, 16'hE000, 32'h0000_0002, 32'h0000_0000, 16'h0000);
		pulse(2);
		wait_steps(2);
		check(speed, 16'hF000);
		pulse(1);
		tick(4);
		check(speed, 16'hE000);
		wait_steps(count + 1);
		c0 = count;
		pulse(2);
		wait_done();
		check(count - c0, 32'h0000_0002);
	endtask

	// reset in mid-run drops every output and leaves the axis idle
	task automatic mid_reset();
		go(MODE_INT_STOP, 16'hF000, 16'h0000, 32'h0000_0000, 32'h0000_0000, 16'h0000);
		tick(5);
		check(busy, 1'b1);
		rst_b = 1'b0;
		tick(1);
		check({busy, done, step_out, speed}, 32'h0000_0000);
		tick(3);
		rst_b = 1'b1;
		tick(1);
		c0 = count;
		pulse(1);
		tick(10);
		check(busy, 1'b0);
		check(count - c0, 32'h0000_0000);
	endtask

	initial begin
		mismatches = 0;
		checked = 0;
		rst_b = 1'b0;
		start = 1'b0;
		clr = 1'b1;
		tbl_we = 1'b0;
		intr_one_pin = 1'b0;
		intr_two_pin = 1'b0;
		mode = 3'h0;
		speed_one = 16'h0000;
		speed_two = 16'h0000;
		decel_step = 16'h0000;
		amount_one = 32'h0000_0000;
		amount_two = 32'h0000_0000;
		table_count = 4'h1;
		tbl_waddr = 3'h0;
		tbl_wspeed = 16'h0000;
		tbl_wamount = 32'h0000_0000;
		tick(16);
		rst_b = 1'b1;
		clr = 1'b0;
		tick(1);
		idle_intr();
		one_speed();
		two_speed();
		multi();
		int_stop();
		int_feed_one();
		int_feed_two();
		mid_reset();
		stop_test();
	end
endmodule // testbench
